// >>> verilog/pvc_pkg.sv
// Shared constants and types for the pulse and velocity command unit.
package pvc_pkg;
    // Clock and servo loop timing.
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned LOOP_PERIOD_NS = 125000;
    localparam int unsigned LOOP_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    // Ramp step numerator for a rate unit of 0.1 ms/kRPM.
    localparam logic [31:0] RAMP_NUM = 32'(LOOP_PERIOD_NS * 10);
    // Position scaling.
    localparam int unsigned REV_SHIFT = 13;
    localparam logic signed [33:0] FE_SAT = 34'sd23456153;
    localparam logic [63:0] MREV_PER_REV = 64'd1000;
    // Register byte offsets.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RATIO_NUM = 8'h04;
    localparam logic [7:0] OFS_RATIO_DEN = 8'h08;
    localparam logic [7:0] OFS_FE_LIMIT = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PULSE_COUNT = 8'h14;
    localparam logic [7:0] OFS_POS_CMD = 8'h18;
    localparam logic [7:0] OFS_ENC_FB = 8'h1c;
    localparam logic [7:0] OFS_REV_FB = 8'h20;
    localparam logic [7:0] OFS_FOLLOW_ERR = 8'h24;
    localparam logic [7:0] OFS_ZERO_OFFSET = 8'h28;
    localparam logic [7:0] OFS_FULL_SCALE_VEL = 8'h2c;
    localparam logic [7:0] OFS_FULL_SCALE_VOLTS = 8'h30;
    localparam logic [7:0] OFS_ANALOG_RATE = 8'h34;
    localparam logic [7:0] OFS_VEL_TOTAL = 8'h38;
    localparam logic [7:0] OFS_PRESET_VEL = 8'h40;
    localparam logic [7:0] OFS_PRESET_RATE = 8'h60;
    // Control field positions.
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_QUAD = 1;
    localparam int unsigned CTL_DIR = 2;
    localparam int unsigned CTL_LIMIT_EN = 3;
    localparam int unsigned CTL_VEL_MODE = 4;
    localparam int unsigned CTL_SUB_LO = 5;
    // Reset values.
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] RATIO_NUM_RST = 32'h0000_0001;
    localparam logic [31:0] RATIO_DEN_RST = 32'h0000_2000;
    localparam logic [31:0] FE_LIMIT_RST = 32'h0000_03e8;
    localparam logic [31:0] FULL_SCALE_VOLTS_RST = 32'h0000_2710;
    // Velocity submodes.
    typedef enum logic [1:0] {
        SUB_ANALOG    = 2'b00,
        SUB_PRESETS   = 2'b01,
        SUB_SUMMATION = 2'b11
    } submode_t;
    // One quadrature or pulse pair input.
    typedef struct packed {
        logic a;
        logic b;
    } quad_t;
endpackage : pvc_pkg

// >>> verilog/pulse_velocity_command_unit.sv
// Pulse decoding, position command, following error and velocity command unit.
//
// Contract
// - Quadrature: B leading counts up, A leading down.
// - Quadrature counts every edge of both channels.
// - Pulse pair: A pulse up, B pulse down.
// - Pulse count is signed total since power-up.
// - Power-up clears count, command and both feedbacks.
// - Only encoder feedback may be preloaded by software.
// - Signed ratio numerator, denominator in master pulses.
// - Position command is pulse count times ratio.
// - Following error is command minus feedback.
// - Disabled drive clears following error.
// - Enabled error limit, pulse mode only.
// - Pulse mode error saturates, never wraps.
// - Enabled limit exceeded raises a fault.
// - Velocity mode drops error at torque maximum.
// - Feedback kept in counts and in revolutions.
// - Direction setting selects counting-up rotation.
// - Analog velocity is scaled offset-corrected input.
// - Analog rate limit, zero disables ramping.
// - Changed analog rate applies at next loop update.
// - Three select lines index eight presets.
// - Selected preset gives target and ramp rate.
// - Ramp toward target, at-velocity when equal.
// - Summation adds analog and preset commands.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module pulse_velocity_command_unit #(
    parameter int unsigned loop_cycles = pvc_pkg::LOOP_CYCLES
) (
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Command and motor encoder pins.
    input  wire pvc_pkg::quad_t      cmd_pins,
    input  wire pvc_pkg::quad_t      fb_pins,
    // Drive inputs.
    input  wire logic [2:0]          preset_select,
    input  wire logic signed [15:0]  analog_input_volts,
    input  wire logic                torque_at_max,
    // Register port.
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic [31:0]              reg_rdata,
    // Command outputs.
    output logic signed [31:0]       position_command,
    output logic signed [31:0]       velocity_command_total,
    output logic                     at_velocity,
    output logic                     following_error_fault
);
    logic rst_meta;
    logic rst_sync;

    // Two-stage release of the asynchronous reset.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    logic [31:0]        control;
    logic signed [31:0] ratio_num;
    logic [31:0]        ratio_den;
    logic [31:0]        fe_limit;

    logic signed [31:0] zero_offset;
    logic signed [31:0] full_scale_velocity;
    logic [31:0]        full_scale_volts;
    logic [31:0]        analog_rate;

    logic signed [31:0] preset_vel [8];
    logic [31:0]        preset_rate [8];

    wire drive_enable = control[pvc_pkg::CTL_ENABLE];
    wire quad_mode    = control[pvc_pkg::CTL_QUAD];
    wire dir_reverse  = control[pvc_pkg::CTL_DIR];
    wire limit_enable = control[pvc_pkg::CTL_LIMIT_EN];
    wire vel_mode     = control[pvc_pkg::CTL_VEL_MODE];

    wire pvc_pkg::submode_t submode = pvc_pkg::submode_t'(control[pvc_pkg::CTL_SUB_LO +: 2]);

    wire wr_control  = reg_write && reg_addr == pvc_pkg::OFS_CONTROL;
    wire wr_num      = reg_write && reg_addr == pvc_pkg::OFS_RATIO_NUM;
    wire wr_den      = reg_write && reg_addr == pvc_pkg::OFS_RATIO_DEN;
    wire wr_limit    = reg_write && reg_addr == pvc_pkg::OFS_FE_LIMIT;
    wire wr_status   = reg_write && reg_addr == pvc_pkg::OFS_STATUS;

    wire wr_enc_fb   = reg_write && reg_addr == pvc_pkg::OFS_ENC_FB;

    wire wr_zero     = reg_write && reg_addr == pvc_pkg::OFS_ZERO_OFFSET;
    wire wr_fsv      = reg_write && reg_addr == pvc_pkg::OFS_FULL_SCALE_VEL;
    wire wr_afs      = reg_write && reg_addr == pvc_pkg::OFS_FULL_SCALE_VOLTS;
    wire wr_rate     = reg_write && reg_addr == pvc_pkg::OFS_ANALOG_RATE;

    // Configuration registers.
    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            control             <= pvc_pkg::CONTROL_RST;
            ratio_num           <= pvc_pkg::RATIO_NUM_RST;
            ratio_den           <= pvc_pkg::RATIO_DEN_RST;
            fe_limit            <= pvc_pkg::FE_LIMIT_RST;
            zero_offset         <= '0;
            full_scale_velocity <= '0;
            full_scale_volts    <= pvc_pkg::FULL_SCALE_VOLTS_RST;
            analog_rate         <= '0;
        end
        else
        begin
            if (wr_control) control <= reg_wdata;
            if (wr_num) ratio_num <= reg_wdata;
            if (wr_den) ratio_den <= reg_wdata;
            if (wr_limit) fe_limit <= reg_wdata;
            if (wr_zero) zero_offset <= reg_wdata;
            if (wr_fsv) full_scale_velocity <= reg_wdata;
            if (wr_afs) full_scale_volts <= reg_wdata;
            if (wr_rate) analog_rate <= reg_wdata;
        end
    end

    // Preset velocity and rate tables.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_preset
            wire wr_v = reg_write && reg_addr == pvc_pkg::OFS_PRESET_VEL + 8'(gi * 4);
            wire wr_r = reg_write && reg_addr == pvc_pkg::OFS_PRESET_RATE + 8'(gi * 4);

            always_ff @(posedge ref_clk or negedge rst_sync)
            begin
                if (!rst_sync)
                begin
                    preset_vel[gi]  <= '0;
                    preset_rate[gi] <= '0;
                end
                else
                begin
                    if (wr_v) preset_vel[gi] <= reg_wdata;
                    if (wr_r) preset_rate[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // One decoder step.
    function automatic logic signed [1:0] decode(input pvc_pkg::quad_t old_s,
                                                 input pvc_pkg::quad_t new_s,
                                                 input logic quad);
        logic [1:0] o;
        logic [1:0] n;
        logic [1:0] fwd;

        o = {old_s.a, old_s.b};
        n = {new_s.a, new_s.b};
        fwd = {o[0], ~o[1]};
        decode = 2'sd0;

        if (!quad)
            decode = 2'(signed'({1'b0, n[1] & ~o[1]}) - signed'({1'b0, n[0] & ~o[0]}));
        else if (o != n && (o ^ n) != 2'b11)
            decode = (n == fwd) ? 2'sd1 : -2'sd1;
    endfunction : decode

    pvc_pkg::quad_t     prev_pins [2];
    logic signed [1:0]  step [2];
    wire pvc_pkg::quad_t pins_now [2] = '{cmd_pins, fb_pins};

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_dec
            always_ff @(posedge ref_clk or negedge rst_sync)
            begin
                if (!rst_sync)
                    prev_pins[gi] <= '0;
                else
                    prev_pins[gi] <= pins_now[gi];
            end
            assign step[gi] = decode(prev_pins[gi], pins_now[gi], gi == 0 ? quad_mode : 1'b1);
        end
    endgenerate

    logic signed [31:0] pulse_count;
    logic signed [31:0] encoder_feedback;
    logic signed [33:0] follow_err;

    wire signed [1:0]  fb_step  = dir_reverse ? -step[1] : step[1];

    wire signed [31:0] rev_feedback = encoder_feedback >>> pvc_pkg::REV_SHIFT;

    // Ratio product in encoder counts.
    wire signed [63:0] cmd_product = (64'(pulse_count) * 64'(ratio_num))
                                     <<< pvc_pkg::REV_SHIFT;
    wire signed [63:0] cmd_quot = ratio_den == '0 ? 64'sd0
                                  : cmd_product / signed'({32'h0, ratio_den});
    wire signed [31:0] next_position_command = cmd_quot[31:0];

    wire signed [33:0] cmd_delta = 34'(next_position_command) - 34'(position_command);
    wire signed [33:0] raw_err   = follow_err + cmd_delta - 34'(fb_step);
    wire signed [33:0] sat_err   = raw_err > pvc_pkg::FE_SAT ? pvc_pkg::FE_SAT
                                 : raw_err < -pvc_pkg::FE_SAT ? -pvc_pkg::FE_SAT
                                 : raw_err;

    wire [33:0] abs_new = sat_err[33] ? 34'(-sat_err) : sat_err;
    wire [33:0] abs_old = follow_err[33] ? 34'(-follow_err) : follow_err;

    wire        err_drop = vel_mode && torque_at_max && abs_new > abs_old;
    wire signed [33:0] next_follow_err = !drive_enable ? 34'sd0
                                       : err_drop ? follow_err : sat_err;

    wire [63:0] err_scaled   = 64'(abs_old) * pvc_pkg::MREV_PER_REV;
    wire [63:0] limit_scaled = 64'(fe_limit) << pvc_pkg::REV_SHIFT;
    wire        limit_hit = !vel_mode && limit_enable && err_scaled > limit_scaled;

    // Position, error and fault registers.
    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pulse_count           <= '0;
            position_command      <= '0;
            encoder_feedback      <= '0;
            follow_err            <= '0;
            following_error_fault <= 1'b0;
        end
        else
        begin
            pulse_count      <= pulse_count + 32'(step[0]);
            position_command <= next_position_command;
            if (wr_enc_fb)
                encoder_feedback <= reg_wdata;
            else
                encoder_feedback <= encoder_feedback + 32'(fb_step);

            follow_err <= next_follow_err;

            if (limit_hit)
                following_error_fault <= 1'b1;
            else if (wr_status && reg_wdata[0])
                following_error_fault <= 1'b0;
        end
    end

    // Servo loop update tick.
    logic [31:0] loop_count;
    wire         loop_tick = loop_count == 32'(loop_cycles - 1);

    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            loop_count <= '0;
        else
            loop_count <= loop_tick ? 32'h0 : loop_count + 32'h1;
    end

    // One rate-limited step toward a target.
    function automatic logic signed [31:0] ramp(input logic signed [31:0] cur,
                                                input logic signed [31:0] tgt,
                                                input logic [31:0] rate);
        logic signed [33:0] diff;
        logic signed [33:0] lim;

        diff = 34'(tgt) - 34'(cur);
        lim  = rate == '0 ? 34'sd0 : signed'({2'b00, pvc_pkg::RAMP_NUM / rate});

        if (rate == '0)
            ramp = tgt;
        else if (diff > lim)
            ramp = 32'(34'(cur) + lim);
        else if (diff < -lim)
            ramp = 32'(34'(cur) - lim);
        else
            ramp = tgt;
    endfunction : ramp

    // Analog velocity in milli-RPM.
    wire signed [63:0] analog_num = (64'(analog_input_volts) - 64'(zero_offset))
                                    * 64'(full_scale_velocity) * 64'sd1000;
    wire signed [63:0] analog_quot = full_scale_volts == '0 ? 64'sd0
                                     : analog_num / signed'({32'h0, full_scale_volts});
    wire signed [31:0] analog_target = analog_quot[31:0];

    wire signed [31:0] target_velocity = preset_vel[preset_select];
    wire [31:0]        target_rate     = preset_rate[preset_select];

    logic signed [31:0] analog_velocity_command;
    logic signed [31:0] preset_velocity_command;

    wire signed [31:0] analog_velocity_term = analog_velocity_command;
    wire signed [31:0] next_velocity_total =
        !vel_mode ? 32'sd0
        : submode == pvc_pkg::SUB_ANALOG ? analog_velocity_term
        : submode == pvc_pkg::SUB_PRESETS ? preset_velocity_command
        : analog_velocity_term + preset_velocity_command;

    // Velocity commands: ramps on the servo loop tick, total and at-velocity every clock.
    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            analog_velocity_command <= '0;
            preset_velocity_command <= '0;
            velocity_command_total  <= '0;
            at_velocity             <= 1'b0;
        end
        else
        begin
            if (loop_tick)
            begin
                analog_velocity_command <= ramp(analog_velocity_command,
                                                analog_target, analog_rate);
                preset_velocity_command <= ramp(preset_velocity_command,
                                                target_velocity, target_rate);
            end

            velocity_command_total <= next_velocity_total;
            at_velocity <= preset_velocity_command == target_velocity;
        end
    end

    // Register read data.
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;

        case (reg_addr)
            pvc_pkg::OFS_CONTROL:          rd_mux = control;
            pvc_pkg::OFS_RATIO_NUM:        rd_mux = ratio_num;
            pvc_pkg::OFS_RATIO_DEN:        rd_mux = ratio_den;
            pvc_pkg::OFS_FE_LIMIT:         rd_mux = fe_limit;
            pvc_pkg::OFS_STATUS:           rd_mux = {30'h0, at_velocity, following_error_fault};
            pvc_pkg::OFS_PULSE_COUNT:      rd_mux = pulse_count;
            pvc_pkg::OFS_POS_CMD:          rd_mux = position_command;
            pvc_pkg::OFS_ENC_FB:           rd_mux = encoder_feedback;
            pvc_pkg::OFS_REV_FB:           rd_mux = rev_feedback;
            pvc_pkg::OFS_FOLLOW_ERR:       rd_mux = follow_err[31:0];
            pvc_pkg::OFS_ZERO_OFFSET:      rd_mux = zero_offset;
            pvc_pkg::OFS_FULL_SCALE_VEL:   rd_mux = full_scale_velocity;
            pvc_pkg::OFS_FULL_SCALE_VOLTS: rd_mux = full_scale_volts;
            pvc_pkg::OFS_ANALOG_RATE:      rd_mux = analog_rate;
            pvc_pkg::OFS_VEL_TOTAL:        rd_mux = velocity_command_total;
            default:
            begin
                if (reg_addr[7:5] == 3'h2 && reg_addr[1:0] == 2'h0)
                    rd_mux = preset_vel[reg_addr[4:2]];
                else if (reg_addr[7:5] == 3'h3 && reg_addr[1:0] == 2'h0)
                    rd_mux = preset_rate[reg_addr[4:2]];
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_read ? rd_mux : 32'h0;
    end
endmodule : pulse_velocity_command_unit
`default_nettype wire

// >>> verification/pvc_props.sv
// Port checker for the command unit.
`timescale 1ns/1ns
`default_nettype none
module pvc_props (
    // Clock and reset.
    input wire logic                ref_clk,
    input wire logic                rst_n,
    // Inputs.
    input wire pvc_pkg::quad_t      cmd_pins,
    input wire logic [7:0]          reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_write,
    input wire logic                reg_read,
    // Outputs.
    input wire logic [31:0]         reg_rdata,
    input wire logic signed [31:0]  position_command,
    input wire logic signed [31:0]  velocity_command_total,
    input wire logic                at_velocity,
    input wire logic                following_error_fault
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    property p_reset_clear;
        $rose(rst_n) |-> (position_command == 32'sh0 && velocity_command_total == 32'sh0
            && !following_error_fault && !at_velocity)[*2];
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset outputs");
    property p_pos_hold;
        ($stable(cmd_pins) && !reg_write)[*4] |=> $stable(position_command);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("command moved");
    property p_double_toggle;
        ($stable(cmd_pins) && !reg_write)[*4] ##1 (cmd_pins.a != $past(cmd_pins.a)
            && cmd_pins.b != $past(cmd_pins.b) && !reg_write) ##1
            ($stable(cmd_pins) && !reg_write)[*4] |-> position_command == $past(position_command, 5);
    endproperty
    a_double_toggle: assert property (p_double_toggle) else $error("double toggle");
    property p_fault_sticky;
        following_error_fault && !(reg_write && reg_addr == pvc_pkg::OFS_STATUS && reg_wdata[0])
            |=> following_error_fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped");
    property p_read_pos;
        reg_read && reg_addr == pvc_pkg::OFS_POS_CMD |=> reg_rdata == $past(position_command);
    endproperty
    a_read_pos: assert property (p_read_pos) else $error("command read");
    property p_read_status;
        reg_read && reg_addr == pvc_pkg::OFS_STATUS
            |=> reg_rdata[1:0] == {$past(at_velocity), $past(following_error_fault)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read");
    property p_read_vel;
        reg_read && reg_addr == pvc_pkg::OFS_VEL_TOTAL |=> reg_rdata == $past(velocity_command_total);
    endproperty
    a_read_vel: assert property (p_read_vel) else $error("velocity read");
    property p_unmapped;
        reg_read && reg_addr >= 8'h80 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : pvc_props
`default_nettype wire

// >>> verification/pulse_source.sv
// Quadrature pulse source model.
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
    // Clock.
    input wire logic              ref_clk,
    // Pulse lines.
    output var pvc_pkg::quad_t    pins
);
    initial pins = 2'h0;
    task automatic quad_steps(input int n, input logic up, input int gap);
        repeat (n)
        begin
            @(posedge ref_clk);
            pins <= up ? {pins.b, ~pins.a} : {~pins.b, pins.a};
            repeat (gap) @(posedge ref_clk);
        end
    endtask : quad_steps
    task automatic pulses(input logic on_a, input int n, input int gap);
        repeat (n)
        begin
            @(posedge ref_clk);
            pins <= on_a ? 2'h2 : 2'h1;
            repeat (gap) @(posedge ref_clk);
            pins <= 2'h0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask : pulses
    task automatic flip_both(input int gap);
        @(posedge ref_clk);
        pins <= ~pins;
        repeat (gap) @(posedge ref_clk);
    endtask : flip_both
endmodule : pulse_source
`default_nettype wire

// >>> verification/testbench.sv
// Testbench for the command unit.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("Error %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module testbench;
    logic                ref_clk;
    logic                rst_n;
    pvc_pkg::quad_t      cmd_pins;
    pvc_pkg::quad_t      fb_pins;
    logic [2:0]          preset_select;
    logic signed [15:0]  analog_input_volts;
    logic                torque_at_max;
    logic [7:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_write;
    logic                reg_read;
    logic [31:0]         reg_rdata;
    logic signed [31:0]  position_command;
    logic signed [31:0]  velocity_command_total;
    logic                at_velocity;
    logic                following_error_fault;
    logic [31:0]         exp_q[$];
    logic [31:0]         exp_now;
    logic                rd_seen;
    logic [15:0]         rnd;
    int                  errors;
    int                  checks;
    pulse_source cmd_src (.ref_clk(ref_clk), .pins(cmd_pins));
    pulse_source fb_src (.ref_clk(ref_clk), .pins(fb_pins));
    pulse_velocity_command_unit #(.loop_cycles(10)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cmd_pins(cmd_pins), .fb_pins(fb_pins),
        .preset_select(preset_select), .analog_input_volts(analog_input_volts),
        .torque_at_max(torque_at_max), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .position_command(position_command), .velocity_command_total(velocity_command_total),
        .at_velocity(at_velocity), .following_error_fault(following_error_fault));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
    endtask : rd
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk)
    begin
        if (rd_seen)
        begin
            exp_now = exp_q.pop_front();
            `CHECK("reg_rdata", exp_now, reg_rdata)
        end
        rd_seen <= reg_read;
    end
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        errors++;
        end_of_test();
    end
    initial
    begin
        int n;
        int r;
        rst_n = 1'b0;
        preset_select = 3'h0;
        analog_input_volts = 16'sh0;
        torque_at_max = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        rnd = 16'd54222;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(pvc_pkg::OFS_CONTROL, pvc_pkg::CONTROL_RST);
        rd(pvc_pkg::OFS_RATIO_NUM, pvc_pkg::RATIO_NUM_RST);
        rd(pvc_pkg::OFS_RATIO_DEN, pvc_pkg::RATIO_DEN_RST);
        rd(pvc_pkg::OFS_FE_LIMIT, pvc_pkg::FE_LIMIT_RST);
        rd(pvc_pkg::OFS_PULSE_COUNT, 32'h0);
        rd(pvc_pkg::OFS_ENC_FB, 32'h0);
        rd(8'hf0, 32'h0);
        $display("done: reset");
        wr(pvc_pkg::OFS_CONTROL, 32'h2);
        rnd = lfsr(rnd);
        n = 5 + int'(rnd[2:0]);
        cmd_src.quad_steps(n, 1'b1, 2 + int'(rnd[4:3]));
        repeat (3) @(posedge ref_clk);
        `CHECK("position_command", 32'(n), position_command)
        cmd_src.quad_steps(n - 4, 1'b0, 3);
        cmd_src.flip_both(5);
        cmd_src.flip_both(5);
        rd(pvc_pkg::OFS_PULSE_COUNT, 32'h4);
        $display("done: quadrature");
        wr(pvc_pkg::OFS_FE_LIMIT, 32'h1);
        wr(pvc_pkg::OFS_CONTROL, 32'h9);
        cmd_src.pulses(1'b1, 8, 2);
        repeat (3) @(posedge ref_clk);
        `CHECK("following_error_fault", 1'b0, following_error_fault)
        cmd_src.pulses(1'b1, 1, 2);
        repeat (3) @(posedge ref_clk);
        `CHECK("following_error_fault", 1'b1, following_error_fault)
        fb_src.quad_steps(3, 1'b1, 2);
        repeat (3) @(posedge ref_clk);
        rd(pvc_pkg::OFS_FOLLOW_ERR, 32'h6);
        rd(pvc_pkg::OFS_ENC_FB, 32'h3);
        cmd_src.pulses(1'b0, 3, 2);
        rd(pvc_pkg::OFS_PULSE_COUNT, 32'd10);
        wr(pvc_pkg::OFS_CONTROL, 32'h0);
        rd(pvc_pkg::OFS_FOLLOW_ERR, 32'h0);
        wr(pvc_pkg::OFS_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        `CHECK("following_error_fault", 1'b0, following_error_fault)
        $display("done: following error");
        wr(pvc_pkg::OFS_ENC_FB, 32'd24576);
        wr(pvc_pkg::OFS_PULSE_COUNT, 32'h55);
        rd(pvc_pkg::OFS_ENC_FB, 32'd24576);
        rd(pvc_pkg::OFS_REV_FB, 32'h3);
        rd(pvc_pkg::OFS_PULSE_COUNT, 32'd10);
        wr(pvc_pkg::OFS_RATIO_NUM, 32'hffff_ffff);
        repeat (3) @(posedge ref_clk);
        rd(pvc_pkg::OFS_POS_CMD, 32'hffff_fff6);
        $display("done: preload");
        for (int i = 0; i < 8; i++)
            wr(pvc_pkg::OFS_PRESET_VEL + 8'(4 * i), 32'(1000 * (i + 1)));
        wr(pvc_pkg::OFS_PRESET_RATE + 8'h1c, 32'd1250);
        wr(pvc_pkg::OFS_CONTROL, 32'h31);
        for (int i = 0; i < 7; i++)
        begin
            preset_select <= 3'(i);
            repeat (30) @(posedge ref_clk);
            `CHECK("velocity_command_total", 32'(1000 * (i + 1)), velocity_command_total)
        end
        preset_select <= 3'h0;
        repeat (30) @(posedge ref_clk);
        preset_select <= 3'h7;
        repeat (12) @(posedge ref_clk);
        `CHECK("at_velocity", 1'b0, at_velocity)
        n = 0;
        while (at_velocity !== 1'b1 && n < 500)
        begin
            @(posedge ref_clk);
            n++;
        end
        `CHECK("ramp_wait", 1'b1, n < 500)
        repeat (2) @(posedge ref_clk);
        `CHECK("velocity_command_total", 32'd8000, velocity_command_total)
        rd(pvc_pkg::OFS_STATUS, 32'h2);
        $display("done: presets");
        wr(pvc_pkg::OFS_ZERO_OFFSET, 32'd1000);
        wr(pvc_pkg::OFS_FULL_SCALE_VEL, 32'd3000);
        wr(pvc_pkg::OFS_CONTROL, 32'h11);
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            r = int'(rnd[9:0]) % 1000;
            analog_input_volts <= 16'(1000 + 10 * r);
            repeat (30) @(posedge ref_clk);
            `CHECK("velocity_command_total", 32'(3000 * r), velocity_command_total)
        end
        wr(pvc_pkg::OFS_CONTROL, 32'h71);
        repeat (30) @(posedge ref_clk);
        rd(pvc_pkg::OFS_VEL_TOTAL, 32'(3000 * r + 8000));
        repeat (2) @(posedge ref_clk);
        $display("done: analog");
        end_of_test();
    end
endmodule : testbench
bind pulse_velocity_command_unit pvc_props props (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_pins(cmd_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .position_command(position_command), .velocity_command_total(velocity_command_total),
    .at_velocity(at_velocity), .following_error_fault(following_error_fault));
`default_nettype wire
